// ==== hdl/szc_fifo.sv ====
// Transmit FIFO with valid/ready on both sides
`timescale 1ns/1ps
module szc_fifo #(
	parameter int unsigned WIDTH = szc_pkg::FIFO_W,
	parameter int unsigned DEPTH = szc_pkg::FIFO_DEPTH
) (
	input  wire logic                     clk_in,
	input  wire logic                     srst_in,
	input  wire logic                     ce_in,
	input  wire logic                     in_valid_in,
	output logic                          in_ready_out,
	input  wire logic [WIDTH-1:0]         in_data_in,
	output logic                          out_valid_out,
	input  wire logic                     out_ready_in,
	output logic [WIDTH-1:0]              out_data_out,
	output logic [$clog2(DEPTH):0]        count_out
);
	localparam int unsigned AW = $clog2(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("szc_fifo depth must be a power of two of at least two");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wr_ptr_q;
	logic [AW:0]      rd_ptr_q;
	wire              push;
	wire              pop;

	assign count_out     = wr_ptr_q - rd_ptr_q;
	assign in_ready_out  = count_out != (AW + 1)'(DEPTH);
	assign out_valid_out = count_out != '0;
	assign out_data_out  = mem_q[rd_ptr_q[AW-1:0]];
	assign push          = ce_in & in_valid_in & in_ready_out;
	assign pop           = ce_in & out_valid_out & out_ready_in;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_q[wr_ptr_q[AW-1:0]] <= in_data_in;
		end
	end
endmodule

// ==== hdl/szc_pkg.sv ====
// Register map, field layout, timing counts and types of the serial-zero control block
package szc_pkg;
	localparam int unsigned ADDR_W     = 12;
	localparam int unsigned DATA_W     = 32;
	localparam int unsigned FIFO_DEPTH = 32;
	localparam int unsigned FIFO_W     = 8;

	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_PCON  = 8'h87;
	localparam logic [7:0] IDX_CTRL  = 8'h9b;
	localparam logic [7:0] IDX_BUF   = 8'h9c;
	localparam logic [7:0] IDX_BRCON = 8'hd8;
	localparam logic [7:0] IDX_BRG   = 8'he0;
	localparam logic [7:0] IDX_STAT  = 8'he1;

	localparam logic [11:0] ADDR_PCON  = {2'h0, IDX_PCON, 2'h0};
	localparam logic [11:0] ADDR_CTRL  = {2'h0, IDX_CTRL, 2'h0};
	localparam logic [11:0] ADDR_BUF   = {2'h0, IDX_BUF, 2'h0};
	localparam logic [11:0] ADDR_BRCON = {2'h0, IDX_BRCON, 2'h0};
	localparam logic [11:0] ADDR_BRG   = {2'h0, IDX_BRG, 2'h0};
	localparam logic [11:0] ADDR_STAT  = {2'h0, IDX_STAT, 2'h0};

	localparam int unsigned BIT_BAUD_DOUBLE = 7;
	localparam int unsigned BIT_BAUD_SEL    = 7;
	localparam int unsigned BIT_NINTH_RX    = 2;

	localparam logic [7:0]  CTRL_RST = 8'h00;
	localparam logic [15:0] BRG_RST  = 16'h0000;

	// Baud ticks per bit, normal and doubled
	localparam logic [5:0] TICKS_NORM = 6'h20;
	localparam logic [5:0] TICKS_DBL  = 6'h10;
	// Frame lengths in bits, and index of the last received bit after the start bit
	localparam logic [3:0] BITS_8BIT    = 4'ha;
	localparam logic [3:0] BITS_9BIT    = 4'hb;
	localparam logic [3:0] RX_LAST_8BIT = 4'h8;
	localparam logic [3:0] RX_LAST_9BIT = 4'h9;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic mode_high;
		logic mode_low;
		logic multiproc_enable;
		logic receive_enable_zero;
		logic transmit_ninth_bit;
		logic received_ninth_bit;
		logic transmit_done_flag;
		logic receive_done_flag;
	} szc_ctrl_s;

	typedef enum logic [1:0] {MODE_NA, MODE_8BIT, MODE_9FIX, MODE_9VAR} szc_mode_e;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} szc_rx_e;
endpackage

// ==== hdl/szc_top.sv ====
// Serial-zero control, status and frame engine behind an AXI4-Lite slave
//
// Summary of operation
// R1: Control register at index 0x9b, eight bits, all zeros after reset.
// R2: Control bits msb first: mode high, mode low, mp, rx enable, tb8, rb8, ti, ri.
// R3: Mode bits select: 00 unavailable, 01 8-bit, 10 and 11 9-bit frames.
// R4: Mode 3 is mode 2 with baud from internal generator or timer 1.
// R5: Multiprocessor enable turns on address filtering between processors in the 9-bit modes.
// R6: Frames are received only while receive enable is set.
// R7: In modes 2 and 3 the ninth received bit goes to rb8.
// R8: In mode 1 with mp clear the stop bit goes to rb8.
// R9: Hardware changes rb8 only by loading a received bit; software clears it; unused in mode 0.
// R10: Transmit-done flag sets at frame end and stays until software writes zero.
// R11: Receive-done flag sets at frame end and stays until software writes zero.
// R12: Buffer writes supply the byte to send; reads return the last byte received.
// R13: Mode 1 frame: start zero, eight data lsb first, stop one.
// R14: Mode 2 frame adds tb8 as ninth bit; baud is clock over 32 or 64.
// R15: Baud source select zero picks timer 1 overflow, one the baud generator.
// R16: Baud double set halves the bit time.
// R17: 9-bit modes with mp set drop frames whose ninth bit is zero.
// R18: tb8 is kept as written and sent as ninth bit in 9-bit modes.
`timescale 1ns/1ps
module szc_top #(
	parameter int unsigned FIFO_DEPTH = szc_pkg::FIFO_DEPTH
) (
	input  wire logic                        clk_in,
	input  wire logic                        srst_in,
	input  wire logic                        ce_in,
	input  wire logic [szc_pkg::ADDR_W-1:0]  s_axi_awaddr_in,
	input  wire logic                        s_axi_awvalid_in,
	output logic                             s_axi_awready_out,
	input  wire logic [szc_pkg::DATA_W-1:0]  s_axi_wdata_in,
	input  wire logic [3:0]                  s_axi_wstrb_in,
	input  wire logic                        s_axi_wvalid_in,
	output logic                             s_axi_wready_out,
	output logic [1:0]                       s_axi_bresp_out,
	output logic                             s_axi_bvalid_out,
	input  wire logic                        s_axi_bready_in,
	input  wire logic [szc_pkg::ADDR_W-1:0]  s_axi_araddr_in,
	input  wire logic                        s_axi_arvalid_in,
	output logic                             s_axi_arready_out,
	output logic [szc_pkg::DATA_W-1:0]       s_axi_rdata_out,
	output logic [1:0]                       s_axi_rresp_out,
	output logic                             s_axi_rvalid_out,
	input  wire logic                        s_axi_rready_in,
	input  wire logic                        timer1_ovf_in,
	input  wire logic                        rxd_in,
	output logic                             txd_out
);
	if (FIFO_DEPTH < 2 || FIFO_DEPTH > 32 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk
		$error("szc_top FIFO_DEPTH must be a power of two from 2 to 32");
	end

	szc_pkg::szc_ctrl_s serial_zero_control_q;
	szc_pkg::szc_ctrl_s ctrl_wr_val;
	szc_pkg::szc_ctrl_s ctrl_d;
	szc_pkg::szc_mode_e mode;
	szc_pkg::szc_rx_e   rx_state_q;
	logic [7:0]         serial_zero_buffer_q;
	logic               baud_double_q;
	logic               baud_source_select_q;
	logic [15:0]        brg_reload_q;
	logic [15:0]        brg_cnt_q;
	logic               pre2_q;
	logic               aw_held_q;
	logic               w_held_q;
	logic [11:0]        aw_addr_q;
	logic [31:0]        w_data_q;
	logic [3:0]         w_strb_q;
	logic               bvalid_q;
	logic [1:0]         bresp_q;
	logic               rvalid_q;
	logic [1:0]         rresp_q;
	logic [31:0]        rdata_q;
	logic               tx_busy_q;
	logic [10:0]        tx_sh_q;
	logic [3:0]         tx_cnt_q;
	logic [5:0]         tx_tk_q;
	logic [5:0]         rx_tk_q;
	logic [3:0]         rx_idx_q;
	logic [9:0]         rx_sh_q;
	logic [$clog2(FIFO_DEPTH):0] fifo_count;
	logic               fifo_in_ready;
	logic               fifo_out_valid;
	logic [7:0]         fifo_out_data;

	// Mode decode and baud tick selection
	assign mode = szc_pkg::szc_mode_e'({serial_zero_control_q.mode_high,
		serial_zero_control_q.mode_low}); // R3
	wire mode_na  = mode == szc_pkg::MODE_NA; // R3
	wire nine     = serial_zero_control_q.mode_high; // R3
	wire mp       = serial_zero_control_q.multiproc_enable; // R5
	wire brg_tick = brg_cnt_q == 16'h0000;
	wire var_tick = baud_source_select_q ? brg_tick : timer1_ovf_in; // R15 R4
	wire tick     = (mode == szc_pkg::MODE_9FIX) ? pre2_q : var_tick; // R14
	wire [5:0] bit_len = baud_double_q ? szc_pkg::TICKS_DBL : szc_pkg::TICKS_NORM; // R16

	// Write channel decode
	wire w_hit_ctrl  = aw_addr_q[11:2] == szc_pkg::ADDR_CTRL[11:2];
	wire w_hit_buf   = aw_addr_q[11:2] == szc_pkg::ADDR_BUF[11:2];
	wire w_hit_pcon  = aw_addr_q[11:2] == szc_pkg::ADDR_PCON[11:2];
	wire w_hit_brcon = aw_addr_q[11:2] == szc_pkg::ADDR_BRCON[11:2];
	wire w_hit_brg   = aw_addr_q[11:2] == szc_pkg::ADDR_BRG[11:2];
	wire w_hit_stat  = aw_addr_q[11:2] == szc_pkg::ADDR_STAT[11:2];
	wire w_hit_any   = w_hit_ctrl | w_hit_buf | w_hit_pcon | w_hit_brcon | w_hit_brg | w_hit_stat;
	wire wr_ready    = ce_in & aw_held_q & w_held_q & ~bvalid_q;
	// A full transmit FIFO holds off the write response until a slot frees
	wire buf_push    = wr_ready & w_hit_buf & w_strb_q[0]; // R12
	wire wr_fire     = wr_ready & (~buf_push | fifo_in_ready);
	wire wr_ctrl     = wr_fire & w_hit_ctrl & w_strb_q[0];
	wire aw_hs       = s_axi_awvalid_in & s_axi_awready_out;
	wire w_hs        = s_axi_wvalid_in & s_axi_wready_out;
	wire ar_hs       = s_axi_arvalid_in & s_axi_arready_out;

	assign s_axi_awready_out = ce_in & ~aw_held_q & ~bvalid_q;
	assign s_axi_wready_out  = ce_in & ~w_held_q & ~bvalid_q;
	assign s_axi_arready_out = ce_in & ~rvalid_q;
	assign s_axi_bvalid_out  = ce_in & bvalid_q;
	assign s_axi_rvalid_out  = ce_in & rvalid_q;
	assign s_axi_bresp_out   = bresp_q;
	assign s_axi_rresp_out   = rresp_q;
	assign s_axi_rdata_out   = rdata_q;

	// Read decode
	wire [9:0] r_word  = s_axi_araddr_in[11:2];
	wire r_hit_ctrl    = r_word == szc_pkg::ADDR_CTRL[11:2];
	wire r_hit_buf     = r_word == szc_pkg::ADDR_BUF[11:2];
	wire r_hit_pcon    = r_word == szc_pkg::ADDR_PCON[11:2];
	wire r_hit_brcon   = r_word == szc_pkg::ADDR_BRCON[11:2];
	wire r_hit_brg     = r_word == szc_pkg::ADDR_BRG[11:2];
	wire r_hit_stat    = r_word == szc_pkg::ADDR_STAT[11:2];
	wire r_hit_any     = r_hit_ctrl | r_hit_buf | r_hit_pcon | r_hit_brcon | r_hit_brg | r_hit_stat;
	wire [7:0] stat    = {6'(fifo_count), tx_busy_q, rx_state_q != szc_pkg::RX_IDLE};
	wire [31:0] rd_data =
		r_hit_ctrl  ? {24'h0, serial_zero_control_q} :
		r_hit_buf   ? {24'h0, serial_zero_buffer_q} : // R12
		r_hit_pcon  ? {24'h0, baud_double_q, 7'h00} :
		r_hit_brcon ? {24'h0, baud_source_select_q, 7'h00} :
		r_hit_brg   ? {16'h0, brg_reload_q} :
		r_hit_stat  ? {24'h0, stat} : 32'h0;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= szc_pkg::RESP_OKAY;
			aw_addr_q <= '0;
			w_data_q  <= '0;
			w_strb_q  <= '0;
		end else if (ce_in) begin
			if (aw_hs) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr_in;
			end
			if (w_hs) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata_in;
				w_strb_q <= s_axi_wstrb_in;
			end
			if (wr_fire) begin
				aw_held_q <= 1'b0;
				w_held_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= w_hit_any ? szc_pkg::RESP_OKAY : szc_pkg::RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready_in) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rvalid_q <= 1'b0;
			rresp_q  <= szc_pkg::RESP_OKAY;
			rdata_q  <= '0;
		end else if (ce_in) begin
			if (ar_hs) begin
				rvalid_q <= 1'b1;
				rdata_q  <= rd_data;
				rresp_q  <= r_hit_any ? szc_pkg::RESP_OKAY : szc_pkg::RESP_SLVERR;
			end else if (rvalid_q && s_axi_rready_in) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// Transmit engine
	wire tx_start    = ce_in & ~tx_busy_q & fifo_out_valid & ~mode_na; // R3
	wire tx_bit_end  = tick & (tx_tk_q == bit_len - 6'h01);
	wire tx_done     = ce_in & tx_busy_q & tx_bit_end & (tx_cnt_q == 4'h1); // R10
	wire [10:0] tx_frame = nine ?
		{1'b1, serial_zero_control_q.transmit_ninth_bit, fifo_out_data, 1'b0} : // R14 R18
		{2'b11, fifo_out_data, 1'b0}; // R13
	assign txd_out = tx_sh_q[0];

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			tx_busy_q <= 1'b0;
			tx_sh_q   <= '1;
			tx_cnt_q  <= '0;
			tx_tk_q   <= '0;
		end else if (tx_start) begin
			tx_busy_q <= 1'b1;
			tx_sh_q   <= tx_frame;
			tx_cnt_q  <= nine ? szc_pkg::BITS_9BIT : szc_pkg::BITS_8BIT; // R13 R14
			tx_tk_q   <= '0;
		end else if (ce_in && tx_busy_q && tick) begin
			if (tx_bit_end) begin
				tx_tk_q  <= '0;
				tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
				tx_cnt_q <= tx_cnt_q - 4'h1;
				tx_busy_q <= tx_cnt_q != 4'h1;
			end else begin
				tx_tk_q <= tx_tk_q + 6'h01;
			end
		end
	end

	// Receive engine
	wire rx_go     = serial_zero_control_q.receive_enable_zero & ~mode_na; // R6
	wire rx_mid    = rx_tk_q == {1'b0, bit_len[5:1]} - 6'h01;
	wire rx_end    = rx_tk_q == bit_len - 6'h01;
	wire rx_last   = rx_idx_q == (nine ? szc_pkg::RX_LAST_9BIT : szc_pkg::RX_LAST_8BIT);
	wire rx_fin    = ce_in & rx_go & tick & rx_end & rx_last & (rx_state_q == szc_pkg::RX_DATA);
	wire rx_ninth  = nine ? rx_sh_q[8] : rxd_in; // R7 R8
	wire rx_keep   = rx_fin & ~(nine & mp & ~rx_sh_q[8]); // R17
	wire rb8_load  = rx_keep & (nine | ~mp); // R7 R8

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rx_state_q <= szc_pkg::RX_IDLE;
			rx_tk_q    <= '0;
			rx_idx_q   <= '0;
			rx_sh_q    <= '0;
		end else if (ce_in) begin
			unique case (rx_state_q)
				szc_pkg::RX_IDLE: begin
					rx_tk_q <= '0;
					if (rx_go && !rxd_in) begin // R6 R13
						rx_state_q <= szc_pkg::RX_START;
					end
				end
				szc_pkg::RX_START: begin
					if (!rx_go) begin
						rx_state_q <= szc_pkg::RX_IDLE;
					end else if (tick && rx_mid) begin
						rx_state_q <= rxd_in ? szc_pkg::RX_IDLE : szc_pkg::RX_DATA;
						rx_tk_q    <= '0;
						rx_idx_q   <= '0;
					end else if (tick) begin
						rx_tk_q <= rx_tk_q + 6'h01;
					end
				end
				szc_pkg::RX_DATA: begin
					if (!rx_go) begin
						rx_state_q <= szc_pkg::RX_IDLE;
					end else if (tick && rx_end) begin
						rx_sh_q[rx_idx_q] <= rxd_in;
						rx_idx_q <= rx_idx_q + 4'h1;
						rx_tk_q  <= '0;
						if (rx_last) begin
							rx_state_q <= szc_pkg::RX_IDLE;
						end
					end else if (tick) begin
						rx_tk_q <= rx_tk_q + 6'h01;
					end
				end
				default: rx_state_q <= szc_pkg::RX_IDLE;
			endcase
		end
	end

	// Control register: hardware set wins over a software clear in the same cycle
	assign ctrl_wr_val = wr_ctrl ? szc_pkg::szc_ctrl_s'(w_data_q[7:0]) : serial_zero_control_q;
	assign ctrl_d = {ctrl_wr_val[7:3], // R2 R18
		rb8_load ? rx_ninth : ctrl_wr_val[szc_pkg::BIT_NINTH_RX], // R9
		ctrl_wr_val.transmit_done_flag | tx_done, // R10
		ctrl_wr_val.receive_done_flag | rx_keep}; // R11

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			serial_zero_control_q <= szc_pkg::CTRL_RST; // R1
			serial_zero_buffer_q  <= '0;
		end else if (ce_in) begin
			serial_zero_control_q <= ctrl_d;
			if (rx_keep) begin
				serial_zero_buffer_q <= rx_sh_q[7:0]; // R12
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			baud_double_q        <= 1'b0;
			baud_source_select_q <= 1'b0;
			brg_reload_q         <= szc_pkg::BRG_RST;
		end else if (wr_fire && w_strb_q[0]) begin
			if (w_hit_pcon) baud_double_q <= w_data_q[szc_pkg::BIT_BAUD_DOUBLE];
			if (w_hit_brcon) baud_source_select_q <= w_data_q[szc_pkg::BIT_BAUD_SEL];
			if (w_hit_brg) brg_reload_q[7:0] <= w_data_q[7:0];
		end
		if (!srst_in && wr_fire && w_strb_q[1] && w_hit_brg) begin
			brg_reload_q[15:8] <= w_data_q[15:8];
		end
	end

	// Internal baud generator and fixed-rate prescaler
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			brg_cnt_q <= szc_pkg::BRG_RST;
			pre2_q    <= 1'b0;
		end else if (ce_in) begin
			brg_cnt_q <= brg_tick ? brg_reload_q : brg_cnt_q - 16'h0001;
			pre2_q    <= ~pre2_q;
		end
	end

	szc_fifo #(.WIDTH(szc_pkg::FIFO_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.clk_in        (clk_in),
		.srst_in       (srst_in),
		.ce_in         (ce_in),
		.in_valid_in   (buf_push),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    (w_data_q[7:0]),
		.out_valid_out (fifo_out_valid),
		.out_ready_in  (~tx_busy_q & ~mode_na),
		.out_data_out  (fifo_out_data),
		.count_out     (fifo_count)
	);

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (srst_in || !ce_in);

	AST_CTRL_RESET: assert property (@(posedge clk_in) disable iff (1'b0) // R1
		srst_in |=> serial_zero_control_q == szc_pkg::CTRL_RST)
		else $error("control register not zero after reset");
	AST_TI_SET: assert property (tx_done |=> serial_zero_control_q.transmit_done_flag) // R10
		else $error("transmit done flag not set after frame");
	AST_TI_STICKY: assert property (serial_zero_control_q.transmit_done_flag && !wr_ctrl // R10
		|=> serial_zero_control_q.transmit_done_flag)
		else $error("transmit done flag cleared without software");
	AST_RI_SET: assert property (rx_keep |=> serial_zero_control_q.receive_done_flag // R11
		&& serial_zero_buffer_q == $past(rx_sh_q[7:0]))
		else $error("receive done flag or buffer not updated");
	AST_RX_OFF: assert property (!serial_zero_control_q.receive_enable_zero // R6
		|=> rx_state_q == szc_pkg::RX_IDLE)
		else $error("receiver active while disabled");
	AST_RB8_HOLD: assert property (serial_zero_control_q.received_ninth_bit && !wr_ctrl // R9
		&& !rb8_load
		|=> serial_zero_control_q.received_ninth_bit)
		else $error("ninth bit flag cleared by hardware");
	AST_STOP_RB8: assert property (rx_fin && mode == szc_pkg::MODE_8BIT && !mp // R8
		|=> serial_zero_control_q.received_ninth_bit == $past(rxd_in))
		else $error("stop bit not loaded into ninth bit flag");
	AST_MP_DROP: assert property (rx_fin && nine && mp && !rx_sh_q[8] // R17
		|=> $stable(serial_zero_buffer_q) && !$rose(serial_zero_control_q.receive_done_flag))
		else $error("address filter let a data frame through");
	AST_NINTH_RB8: assert property (rx_keep && nine // R7
		|=> serial_zero_control_q.received_ninth_bit == $past(rx_sh_q[8]))
		else $error("ninth data bit not loaded into flag");
	AST_TX_START: assert property (tx_start |=> (!txd_out && tx_busy_q) [*2]) // R13
		else $error("start bit not driven low");
	AST_MODE0_IDLE: assert property (mode_na && !tx_busy_q |=> txd_out) // R3
		else $error("transmit started in unavailable mode");

	COV_TX_DONE: cover property (tx_done);
	COV_RX_KEEP: cover property (rx_keep);
	COV_MP_DROP: cover property (rx_fin && !rx_keep);
	COV_FIFO_FULL: cover property (buf_push && !fifo_in_ready);
endmodule

// ==== tb/serial_port_zero_control_tb_top.sv ====
// Testbench: register table, frames in both directions, modes, baud sources, FIFO fill
`timescale 1ns/1ps
module serial_port_zero_control_tb_top;
	typedef struct packed {
		logic [11:0] a;
		logic [31:0] w;
		logic [31:0] r;
		logic [1:0]  e;
	} szc_row_s;
	logic        clk_in, srst_in, tick, rxd, txd;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, v;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, resp;
	logic [7:0]  bit_clks;
	logic [3:0]  nbits;
	logic [10:0] frame;
	int          n_frames, n_errors, cmp_count, base;
	szc_row_s    rows [8] = '{
		'{szc_pkg::ADDR_CTRL, 32'h3c, 32'h3c, szc_pkg::RESP_OKAY},
		'{szc_pkg::ADDR_CTRL, 32'h03, 32'h03, szc_pkg::RESP_OKAY},
		'{szc_pkg::ADDR_CTRL, 32'h00, 32'h00, szc_pkg::RESP_OKAY},
		'{szc_pkg::ADDR_PCON, 32'h80, 32'h80, szc_pkg::RESP_OKAY},
		'{szc_pkg::ADDR_PCON, 32'h00, 32'h00, szc_pkg::RESP_OKAY},
		'{szc_pkg::ADDR_BRCON, 32'h80, 32'h80, szc_pkg::RESP_OKAY},
		'{szc_pkg::ADDR_BRG, 32'h00, 32'h00, szc_pkg::RESP_OKAY},
		'{12'h004, 32'h55, 32'h00, szc_pkg::RESP_SLVERR}};

	szc_top i_dut (
		.clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .timer1_ovf_in(tick),
		.rxd_in(rxd), .txd_out(txd));
	szc_peer i_peer (
		.clk_in(clk_in), .txd_in(txd), .bit_clks_in(bit_clks), .nbits_in(nbits),
		.rxd_out(rxd), .frame_out(frame), .count_out(n_frames));

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// Timer-1 overflow pulse every second clock
	always @(posedge clk_in) tick <= ~tick;
	initial begin
		repeat (60000) @(posedge clk_in);
		n_errors++;
		stop_test();
	end

	task automatic stop_test();
		if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Handshakes are sampled at the falling edge and acted on at the next rising edge
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic aw_hs, w_hs, bv;
		@(posedge clk_in);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(negedge clk_in);
			aw_hs = awvalid && awready;
			w_hs = wvalid && wready;
			bv = bvalid;
			resp = bresp;
			@(posedge clk_in);
			if (aw_hs) awvalid <= 1'b0;
			if (w_hs) wvalid <= 1'b0;
			if (bv) begin
				bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic rd(input logic [11:0] a);
		logic ar_hs, rv;
		@(posedge clk_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(negedge clk_in);
			ar_hs = arvalid && arready;
			rv = rvalid;
			v = rdata;
			resp = rresp;
			@(posedge clk_in);
			if (ar_hs) arvalid <= 1'b0;
			if (rv) begin
				rready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
		rd(a);
		chk(nm, v, exp);
	endtask
	function automatic logic [10:0] frm(input logic [7:0] d, input logic n9);
		return {1'b1, n9, d, 1'b0};
	endfunction
	task automatic wait_frames(input int n);
		for (int t = 0; t < 40000 && n_frames < n; t++) @(posedge clk_in);
		chk("frames", {31'h0, n_frames >= n}, 32'h1);
	endtask
	// One byte out; the extra bit time lets the stop bit finish before flags are read
	task automatic tx(input logic [7:0] d, input logic n9);
		base = n_frames;
		wr(szc_pkg::ADDR_BUF, {24'h0, d});
		wait_frames(base + 1);
		chk("frame", {21'h0, frame}, {21'h0, frm(d, n9)});
		repeat (bit_clks) @(posedge clk_in);
	endtask

	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		tick = 1'b0;
		srst_in = 1'b1;
		bit_clks = 8'h20;
		nbits = 4'hb;
		n_errors = 0;
		cmp_count = 0;
		repeat (2) @(posedge clk_in);
		srst_in <= 1'b0;
		rchk("ctrl reset", szc_pkg::ADDR_CTRL, 32'h0);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			chk("bresp", {30'h0, resp}, {30'h0, rows[i].e});
			rd(rows[i].a);
			chk("rdata", v, rows[i].r);
			chk("rresp", {30'h0, resp}, {30'h0, rows[i].e});
		end
		wr(szc_pkg::ADDR_CTRL, 32'hc8);
		tx(8'ha5, 1'b1);
		rchk("ctrl", szc_pkg::ADDR_CTRL, 32'hca);
		wr(szc_pkg::ADDR_CTRL, 32'hd0);
		i_peer.send(frm(8'h5a, 1'b1));
		rchk("ctrl", szc_pkg::ADDR_CTRL, 32'hd5);
		rchk("buffer", szc_pkg::ADDR_BUF, 32'h5a);
		wr(szc_pkg::ADDR_CTRL, 32'hf0);
		i_peer.send(frm(8'h3c, 1'b0));
		rchk("ctrl", szc_pkg::ADDR_CTRL, 32'hf0);
		i_peer.send(frm(8'h3c, 1'b1));
		rchk("ctrl", szc_pkg::ADDR_CTRL, 32'hf5);
		rchk("buffer", szc_pkg::ADDR_BUF, 32'h3c);
		wr(szc_pkg::ADDR_CTRL, 32'hc0);
		i_peer.send(frm(8'h77, 1'b1));
		rchk("ctrl", szc_pkg::ADDR_CTRL, 32'hc0);
		rchk("buffer", szc_pkg::ADDR_BUF, 32'h3c);
		// Mode 1 on timer-1 ticks every second clock: 64 clocks a bit
		wr(szc_pkg::ADDR_BRCON, 32'h0);
		bit_clks = 8'h40;
		nbits = 4'ha;
		wr(szc_pkg::ADDR_CTRL, 32'h50);
		i_peer.send(frm(8'hc3, 1'b1));
		rchk("ctrl", szc_pkg::ADDR_CTRL, 32'h55);
		wr(szc_pkg::ADDR_CTRL, 32'h74);
		i_peer.send(frm(8'h81, 1'b1));
		rchk("ctrl", szc_pkg::ADDR_CTRL, 32'h75);
		tx(8'h96, 1'b1);
		rchk("ctrl", szc_pkg::ADDR_CTRL, 32'h77);
		// Mode 2 doubled: clock over 32
		wr(szc_pkg::ADDR_PCON, 32'h80);
		bit_clks = 8'h20;
		nbits = 4'hb;
		wr(szc_pkg::ADDR_CTRL, 32'h80);
		tx(8'h0f, 1'b0);
		// Generator doubled: 16 clocks a bit; one byte in the shifter, 32 queued
		wr(szc_pkg::ADDR_BRCON, 32'h80);
		bit_clks = 8'h10;
		wr(szc_pkg::ADDR_CTRL, 32'hc0);
		base = n_frames;
		for (int i = 0; i < 33; i++) wr(szc_pkg::ADDR_BUF, i);
		rd(szc_pkg::ADDR_STAT);
		chk("fifo level", {25'h0, v[7:1]}, 32'h41);
		wait_frames(base + 33);
		chk("last frame", {21'h0, frame}, {21'h0, frm(8'h20, 1'b0)});
		chk("frame count", n_frames, base + 33);
		repeat (20) @(posedge clk_in);
		rchk("status", szc_pkg::ADDR_STAT, 32'h0);
		wr(szc_pkg::ADDR_CTRL, 32'h0);
		base = n_frames;
		wr(szc_pkg::ADDR_BUF, 32'h11);
		repeat (400) @(posedge clk_in);
		chk("frame count", n_frames, base);
		// Reset in mid-run with flags set, a byte queued and baud doubling on
		wr(szc_pkg::ADDR_CTRL, 32'h3f);
		srst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		srst_in <= 1'b0;
		rchk("ctrl reset", szc_pkg::ADDR_CTRL, 32'h0);
		rchk("status reset", szc_pkg::ADDR_STAT, 32'h0);
		rchk("double reset", szc_pkg::ADDR_PCON, 32'h0);
		stop_test();
	end
endmodule

// ==== tb/szc_peer.sv ====
// Serial peer model: drives frames into the device and captures the frames it sends
`timescale 1ns/1ps
module szc_peer (
	input  wire logic        clk_in,
	input  wire logic        txd_in,
	input  wire logic [7:0]  bit_clks_in,
	input  wire logic [3:0]  nbits_in,
	output logic             rxd_out,
	output logic [10:0]      frame_out,
	output int               count_out
);
	logic [10:0] f;
	initial begin
		rxd_out = 1'b1;
		frame_out = '1;
		count_out = 0;
	end
	// Frame bits go out lsb first, each held for one bit time
	task automatic send(input logic [10:0] fr);
		for (int i = 0; i < nbits_in; i++) begin
			@(posedge clk_in);
			rxd_out <= fr[i];
			repeat (bit_clks_in - 1) @(posedge clk_in);
		end
	endtask
	// Mid-bit sampling from the falling start edge; no wait after stop, so back to back works
	always begin
		@(negedge txd_in);
		f = '1;
		repeat (bit_clks_in / 2) @(posedge clk_in);
		for (int i = 0; i < nbits_in; i++) begin
			if (i > 0) repeat (bit_clks_in) @(posedge clk_in);
			f[i] = txd_in;
		end
		frame_out = f;
		count_out++;
	end
endmodule
